// ==== hw/fspsc_top.sv ====
// Purpose: Decides where self-programming may run and stalls the CPU
// Assumes: CPU gives fetch address and a one-cycle op request pulse
// Notes:   Fuses and lock bits are static levels from the fuse block
`timescale 1ns/1ps
`default_nettype none
module fspsc_top
   import fspsc_pkg::*;
#(
   parameter int unsigned PROG_CYC = PROG_CYCLES
) (
   input  wire logic              sys_clk,
   input  wire logic              rst,
   input  wire logic [ADDR_W-1:0] fetch_addr,
   input  wire logic              op_req,
   input  wire fspsc_op_t         op_kind,
   input  wire logic [ADDR_W-1:0] z_addr,
   input  wire logic [1:0]        loader_size_fuses,
   input  wire logic [1:0]        lock_set0,
   input  wire logic [1:0]        lock_set1,
   input  wire logic              concurrent_section_reenable,
   input  wire logic [ADDR_W-1:0] read_addr,
   input  wire logic              read_req,
   output logic                   cpu_halt,
   output logic                   concurrent_section_busy,
   output logic                   prog_active,
   output logic                   prog_erase,
   output logic [ADDR_W-1:0]      prog_addr,
   output logic                   op_rejected,
   output logic                   read_blocked
);
   fspsc_if tif ();

   typedef struct packed {
      fspsc_state_t      state;
      logic              halt;
      logic              busy;
      logic              active;
      logic              erase;
      logic [ADDR_W-1:0] addr;
      logic              rejected;
      logic              rd_blk;
      logic              start;
   } fspsc_st_t;

   fspsc_st_t st;
   fspsc_st_t next_st;

   ////////////////////////////////////////////////////////////////////////
   // Section decoding

   // Loader base from fuses; every option sits at or above the stall base
   function automatic logic [ADDR_W-1:0] loader_base(input logic [1:0] f);
      logic [ADDR_W-1:0] b;
      b = LOADER_BASE0;
      case (f)
         2'h0: b = LOADER_BASE0;
         2'h1: b = LOADER_BASE1;
         2'h2: b = LOADER_BASE2;
         default: b = LOADER_BASE3;
      endcase
      return b;
   endfunction

   function automatic logic in_stall(input logic [ADDR_W-1:0] a);
      return a >= STALL_BASE;
   endfunction

   logic              from_loader;
   logic              tgt_loader;
   logic              tgt_locked;
   logic              tgt_stall;
   logic [ADDR_W-1:0] lbase;

   always_comb begin
      lbase = loader_base(loader_size_fuses);
      if (lbase < STALL_BASE) begin
         lbase = STALL_BASE;
      end
      from_loader = fetch_addr >= lbase;
      tgt_loader  = z_addr >= lbase;
      tgt_locked  = tgt_loader ? lock_set1[LOCK_NOWRITE_BIT]
                               : lock_set0[LOCK_NOWRITE_BIT];
      tgt_stall   = in_stall(z_addr);
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencing

   always_comb begin
      next_st          = st;
      next_st.start    = 1'b0;
      next_st.rejected = 1'b0;
      next_st.rd_blk   = read_req && st.busy && !in_stall(read_addr);
      case (st.state)
         FSPSC_IDLE: begin
            if (op_req && op_kind == FSPSC_OP_LOAD) begin
               next_st.busy = 1'b0;
            end else if (op_req && (op_kind == FSPSC_OP_ERASE ||
                                    op_kind == FSPSC_OP_WRITE)) begin
               if (!from_loader || tgt_locked) begin
                  next_st.rejected = 1'b1;
               end else begin
                  next_st.start  = 1'b1;
                  next_st.active = 1'b1;
                  next_st.erase  = op_kind == FSPSC_OP_ERASE;
                  next_st.addr   = z_addr;
                  if (tgt_stall) begin
                     next_st.halt  = 1'b1;
                     next_st.state = FSPSC_RUN_STALL;
                  end else begin
                     next_st.busy  = 1'b1;
                     next_st.state = FSPSC_RUN_CONC;
                  end
               end
            end else if (concurrent_section_reenable) begin
               next_st.busy = 1'b0;
            end
         end
         FSPSC_RUN_CONC: begin
            if (tif.done) begin
               next_st.active = 1'b0;
               next_st.state  = FSPSC_IDLE;
            end
         end
         FSPSC_RUN_STALL: begin
            if (tif.done) begin
               next_st.halt   = 1'b0;
               next_st.active = 1'b0;
               next_st.state  = FSPSC_IDLE;
            end
         end
         default: next_st.state = FSPSC_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign tif.start = st.start;

   fspsc_timer #(
      .PROG_CYC (PROG_CYC)
   ) u_timer (
      .sys_clk (sys_clk),
      .rst     (rst),
      .tif     (tif)
   );

   assign concurrent_section_busy = st.busy;
   assign cpu_halt                = st.halt;
   assign prog_active             = st.active;
   assign prog_erase              = st.erase;
   assign prog_addr               = st.addr;
   assign op_rejected             = st.rejected;
   assign read_blocked            = st.rd_blk;
endmodule
`default_nettype wire

// ==== hw/fspsc_pkg.sv ====
// Purpose: Constants and types for the flash self-program section control block
// Assumes: Word-addressed program flash, 13-bit word address
// Notes:   Page erase/write timing is a parameterised count
// Functional notes
// - Self-program ignored from application section
// - Loader-issued operations may target any page
// - Loader-size fuses set boundary; separate locks
// - Lock set 0 guards application section
// - Lock set 1 guards loader section
// - Target address picks concurrent or stalling
// - Concurrent target: CPU keeps running
// - Stalling target: CPU halted whole operation
// - Loader section always inside stalling section
// - Busy flag high while concurrent section blocked
// - Paging affects only erase and write
// - Busy set when concurrent operation starts
// - Busy cleared by reenable or page load
package fspsc_pkg;
   localparam int unsigned ADDR_W          = 13;
   localparam int unsigned CLK_MHZ         = 200;
   // Page operation time in microseconds
   localparam int unsigned PROG_TIME_US    = 4000;
   localparam int unsigned PROG_CYCLES     = PROG_TIME_US * CLK_MHZ;
   localparam int unsigned CNT_W           = 24;
   // Start of the fixed stalling section (word address)
   localparam logic [ADDR_W-1:0] STALL_BASE = 13'h1800;
   // Loader section base for each fuse code, smallest loader first
   localparam logic [ADDR_W-1:0] LOADER_BASE0 = 13'h1e00;
   localparam logic [ADDR_W-1:0] LOADER_BASE1 = 13'h1c00;
   localparam logic [ADDR_W-1:0] LOADER_BASE2 = 13'h1a00;
   localparam logic [ADDR_W-1:0] LOADER_BASE3 = 13'h1800;
   // Lock modes: bit0 forbids self-program writes to the section
   localparam int unsigned LOCK_NOWRITE_BIT = 0;
   localparam logic [1:0] LOCK_RESET = 2'h0;

   typedef enum logic [1:0] {
      FSPSC_OP_NONE,
      FSPSC_OP_ERASE,
      FSPSC_OP_WRITE,
      FSPSC_OP_LOAD
   } fspsc_op_t;

   typedef enum logic [1:0] {
      FSPSC_IDLE,
      FSPSC_RUN_CONC,
      FSPSC_RUN_STALL
   } fspsc_state_t;
endpackage

// ==== hw/fspsc_if.sv ====
// Purpose: Carrier between controller and timer
// Assumes: Single clock domain
// Notes:   Start is a one-cycle pulse, done a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface fspsc_if;
   logic start;
   logic done;
   modport ctrl (output start, input done);
   modport tmr  (input start, output done);
endinterface
`default_nettype wire

// ==== hw/fspsc_timer.sv ====
// Purpose: Counts the duration of one page erase or write
// Assumes: Start only while idle
// Notes:   Done pulses one cycle after the last count
`timescale 1ns/1ps
`default_nettype none
module fspsc_timer
   import fspsc_pkg::*;
#(
   parameter int unsigned PROG_CYC = PROG_CYCLES
) (
   input  wire logic sys_clk,
   input  wire logic rst,
   fspsc_if.tmr      tif
);
   typedef struct packed {
      logic             busy;
      logic [CNT_W-1:0] cnt;
      logic             done;
   } fspsc_tmr_t;

   fspsc_tmr_t st;
   fspsc_tmr_t next_st;

   always_comb begin
      next_st      = st;
      next_st.done = 1'b0;
      if (st.busy) begin
         if (st.cnt == CNT_W'(1)) begin
            next_st.busy = 1'b0;
            next_st.done = 1'b1;
         end else begin
            next_st.cnt = st.cnt - CNT_W'(1);
         end
      end else if (tif.start) begin
         next_st.busy = 1'b1;
         next_st.cnt  = CNT_W'(PROG_CYC);
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign tif.done = st.done;
endmodule
`default_nettype wire

// ==== tb/fspsc_cpu_model.sv ====
// Purpose: CPU core model that retires one instruction per unhalted cycle
// Assumes: Runs loader code only
// Notes: The retire count lets the bench see stalls
`timescale 1ns/1ps
`default_nettype none
module fspsc_cpu_model (
   input  wire logic   sys_clk,
   input  wire logic   rst,
   input  wire logic   cpu_halt,
   output logic [15:0] retired
);
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst)
         retired <= 16'h0;
      else if (!cpu_halt)
         retired <= retired + 16'h1;
   end
endmodule
`default_nettype wire

// ==== tb/fspsc_top_sva.sv ====
// Purpose: Port checks for flash section control
// Assumes: One clock domain
// Notes: Fetches below 0x1800 are application code under every fuse code
`timescale 1ns/1ps
`default_nettype none
module fspsc_top_sva
   import fspsc_pkg::*;
(
   input wire logic              sys_clk,
   input wire logic              rst,
   input wire logic [ADDR_W-1:0] fetch_addr,
   input wire logic              op_req,
   input wire fspsc_op_t         op_kind,
   input wire logic              concurrent_section_reenable,
   input wire logic [ADDR_W-1:0] read_addr,
   input wire logic              read_req,
   input wire logic              cpu_halt,
   input wire logic              concurrent_section_busy,
   input wire logic              prog_active,
   input wire logic [ADDR_W-1:0] prog_addr,
   input wire logic              op_rejected,
   input wire logic              read_blocked
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   wire pe = op_req && !prog_active && op_kind inside {FSPSC_OP_ERASE, FSPSC_OP_WRITE};
   ////////////////////////////////////////////////////////////
   property p_app; pe && fetch_addr < STALL_BASE |=> op_rejected && !prog_active; endproperty
   a_app: assert property (p_app) else $error("app op ran");
   property p_start; $rose(prog_active) |-> $past(op_req); endproperty
   a_start: assert property (p_start) else $error("op without request");
   property p_halt; cpu_halt == (prog_active && prog_addr >= STALL_BASE); endproperty
   a_halt: assert property (p_halt) else $error("halt mismatch");
   property p_bset; $rose(prog_active) && prog_addr < STALL_BASE
      && $past(op_kind) != FSPSC_OP_LOAD |-> concurrent_section_busy; endproperty
   a_bset: assert property (p_bset) else $error("busy not set");
   property p_reen; concurrent_section_reenable && !prog_active && !op_req
      |=> !concurrent_section_busy; endproperty
   a_reen: assert property (p_reen) else $error("busy not cleared");
   property p_hold; concurrent_section_busy && !op_req
      && !(concurrent_section_reenable && !prog_active) |=> concurrent_section_busy; endproperty
   a_hold: assert property (p_hold) else $error("busy dropped");
   property p_rd; read_req |=> read_blocked
      == ($past(concurrent_section_busy) && $past(read_addr) < STALL_BASE); endproperty
   a_rd: assert property (p_rd) else $error("read block wrong");
   property p_keep; prog_active && op_req |=> $stable(prog_addr); endproperty
   a_keep: assert property (p_keep) else $error("op disturbed");
   cover property ($rose(cpu_halt));
   cover property ($rose(concurrent_section_busy));
   cover property (op_rejected);
endmodule
bind fspsc_top fspsc_top_sva u_sva (.sys_clk, .rst, .fetch_addr, .op_req, .op_kind,
   .concurrent_section_reenable, .read_addr, .read_req, .cpu_halt, .concurrent_section_busy,
   .prog_active, .prog_addr, .op_rejected, .read_blocked);
`default_nettype wire

// ==== tb/fspsc_top_tb.sv ====
// Purpose: Directed bench for flash section control
// Assumes: PROG_CYC shortened to 8
// Notes: flg packs rejected, active, halt, busy
`timescale 1ns/1ps
`default_nettype none
module fspsc_top_tb;
   import fspsc_pkg::*;
   logic              sys_clk, rst, op_req, read_req, concurrent_section_reenable;
   fspsc_op_t         op_kind;
   logic [ADDR_W-1:0] fetch_addr, z_addr, read_addr, prog_addr;
   logic [1:0]        loader_size_fuses, lock_set0, lock_set1;
   logic              cpu_halt, concurrent_section_busy, prog_active, prog_erase;
   logic              op_rejected, read_blocked;
   logic [15:0]       retired, r0;
   int                mismatches, num_checks;
   wire logic [15:0]  flg = {12'h0, op_rejected, prog_active, cpu_halt, concurrent_section_busy};
   localparam logic [3:0]  LK [3] = '{4'h4, 4'h1, 4'h1};
   localparam logic [12:0] ZA [3] = '{13'h1e80, 13'h0100, 13'h1e80};
   localparam logic [15:0] EX [3] = '{16'h8, 16'h8, 16'h6};
   fspsc_top #(.PROG_CYC(8)) dut (.sys_clk, .rst, .fetch_addr, .op_req, .op_kind, .z_addr,
      .loader_size_fuses, .lock_set0, .lock_set1, .concurrent_section_reenable, .read_addr,
      .read_req, .cpu_halt, .concurrent_section_busy, .prog_active, .prog_erase, .prog_addr,
      .op_rejected, .read_blocked);
   fspsc_cpu_model cpu (.sys_clk, .rst, .cpu_halt, .retired);
   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, exp);
      num_checks++;
      if (got !== exp) mismatches++;
      if (got !== exp) $display("Error t=%0t got=%h exp=%h", $time, got, exp);
   endtask
   task automatic summarize;
      if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // One request cycle: bit2 op, bit1 read, bit0 reenable
   task automatic cyc(input logic [2:0] req, input fspsc_op_t k, input logic [12:0] a, f);
      @(posedge sys_clk);
      {op_req, read_req, concurrent_section_reenable} <= req;
      op_kind <= k;
      {z_addr, read_addr, fetch_addr} <= {a, a, f};
      @(posedge sys_clk);
      {op_req, read_req, concurrent_section_reenable} <= 3'h0;
      #1;
   endtask
   task automatic wait_idle;
      for (int i = 0; i < 40 && prog_active !== 1'b0; i++)
         @(posedge sys_clk) #1;
      chk({15'h0, prog_active}, 16'h0);
      if (prog_active !== 1'b0) summarize();
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   initial begin
      {rst, op_req, read_req, concurrent_section_reenable} = 4'h8;
      op_kind = FSPSC_OP_NONE;
      {fetch_addr, z_addr, read_addr} = '0;
      {loader_size_fuses, lock_set0, lock_set1} = 6'h0;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      cyc(3'h4, FSPSC_OP_ERASE, 13'h0100, 13'h0400);
      chk(flg, 16'h8);
      r0 = retired;
      cyc(3'h4, FSPSC_OP_ERASE, 13'h0100, 13'h1f00);
      chk(flg, 16'h5);
      chk({prog_erase, 2'h0, prog_addr}, 16'h8100);
      cyc(3'h2, FSPSC_OP_NONE, 13'h0100, 13'h1f00);
      chk({1'b0, read_blocked, prog_active, prog_addr}, 16'h6100);
      cyc(3'h2, FSPSC_OP_NONE, 13'h1f00, 13'h1f00);
      chk({read_blocked, cpu_halt, 13'h0, retired != r0}, 16'h1);
      cyc(3'h1, FSPSC_OP_NONE, 13'h0000, 13'h1f00);
      chk(flg, 16'h5);
      wait_idle();
      chk(flg, 16'h1);
      cyc(3'h1, FSPSC_OP_NONE, 13'h0000, 13'h1f00);
      chk(flg, 16'h0);
      cyc(3'h4, FSPSC_OP_WRITE, 13'h0200, 13'h1f00);
      chk({prog_erase, 2'h0, prog_addr}, 16'h0200);
      wait_idle();
      cyc(3'h4, FSPSC_OP_LOAD, 13'h0200, 13'h1f00);
      chk({15'h0, concurrent_section_busy}, 16'h0);
      wait_idle();
      cyc(3'h4, FSPSC_OP_WRITE, 13'h1f00, 13'h1f00);
      chk(flg, 16'h6);
      r0 = retired;
      repeat (4) @(posedge sys_clk) #1;
      chk(retired, r0);
      wait_idle();
      @(posedge sys_clk) #1;
      chk({15'h0, retired != r0}, 16'h1);
      for (int i = 0; i < 3; i++) begin
         @(posedge sys_clk);
         {lock_set1, lock_set0} <= LK[i];
         cyc(3'h4, FSPSC_OP_WRITE, ZA[i], 13'h1f00);
         chk(flg, EX[i]);
         wait_idle();
      end
      @(posedge sys_clk);
      lock_set0 <= 2'h0;
      cyc(3'h4, FSPSC_OP_ERASE, 13'h0300, 13'h1900);
      chk(flg, 16'h8);
      @(posedge sys_clk);
      loader_size_fuses <= 2'h3;
      cyc(3'h4, FSPSC_OP_ERASE, 13'h0300, 13'h1900);
      chk(flg, 16'h5);
      wait_idle();
      summarize();
   end
endmodule
`default_nettype wire
